// ===== logic/dual_clock_fifo_port_flags.sv
// port decode, storage, mailboxes and synchronised flags of a 64 x 36 dual-clock fifo
// Notes on behaviour
// - port a idle when deselected; write selects fifo or mail one by mailbox select
// - port a read drives data; with mailbox select reads mail two, sets its flag
// - port b idle when deselected; read drives data; fifo read unless both sizes high
// - both sizes high: read takes mail one and sets its flag, write loads mail two
// - fifo reads from port b are ignored while empty flag is low
// - in byte or word width empty goes low at the last piece
// - read pointer advances whenever a new word enters the port b output register
// - empty controller compares pointers: empty, one above, two above
// - a write shows on empty flag at the second port b rise
// - a port b rise too close to the write defers sync by one cycle
// - full flag low means no free location; port a fifo writes are ignored
// - write pointer advances on each fifo write from port a
// - full controller compares pointers: full, one below, two below
// - a read shows on full flag at the second port a rise
// - a port a rise too close to the read defers sync by one cycle
// - full flags on the port a clock, empty flags on the port b clock
// - each flag passes two flip-flops of its own port clock
// - almost-empty compares pointers against threshold x and its neighbours
// - offset x takes one of four presets during reset, sets both thresholds
// - flag levels follow the fill table against x and 64
// - almost-empty takes two port b rises after a write
// - almost-full takes two port a rises after a read
`timescale 1ns/1ns
`default_nettype none
`include "fifo_port_flags_map.svh"

module dual_clock_fifo_port_flags (
  input wire logic clock,
  input wire logic rstn,
  input wire logic port_b_clock,
  input wire logic [1:0] offset_select,
  input wire fifo_port_flags_pkg::port_a_ctrl_type port_a_ctrl,
  input wire logic [`DATA_W-1:0] port_a_data_in,
  output logic [`DATA_W-1:0] port_a_data_out,
  output logic port_a_data_oe,
  output fifo_port_flags_pkg::port_a_status_type port_a_status,
  input wire fifo_port_flags_pkg::port_b_ctrl_type port_b_ctrl,
  input wire logic [`DATA_W-1:0] port_b_data_in,
  output logic [`DATA_W-1:0] port_b_data_out,
  output logic port_b_data_oe,
  output fifo_port_flags_pkg::port_b_status_type port_b_status
);
  import fifo_port_flags_pkg::*;

  // gray code keeps a pointer crossing to one changing bit per step
  function automatic logic [`PTR_W-1:0] to_gray(input logic [`PTR_W-1:0] b);
    to_gray = b ^ (b >> 1);
  endfunction : to_gray

  function automatic logic [`PTR_W-1:0] from_gray(input logic [`PTR_W-1:0] g);
    logic [`PTR_W-1:0] b;
    b = g;
    for (int i = `PTR_W - 2; i >= 0; i--) begin
      b[i] = b[i+1] ^ g[i];
    end
    from_gray = b;
  endfunction : from_gray

  ////////////////////////////////////////////////////////////////////////////
  // shared storage: written on the port a clock, read on the port b clock
  logic [`DATA_W-1:0] mem [0:`FIFO_DEPTH-1];

  // port a domain state
  logic [`PTR_W-1:0] wp_q, wp_d, wg_q, rg_a1_q, rg_a2_q, rp_a, count_a;
  logic [`PTR_W-1:0] x_q;
  logic [`DATA_W-1:0] mail_one_q, mail_two_a_q;
  logic m1_req_q, m1_ack_a1_q, m1_ack_a2_q;
  logic m2_req_a1_q, m2_req_a2_q, m2_seen_q, mail_two_flag_n_q;

  // port b domain state
  logic [1:0] b_rst_pipe_q;
  logic b_rstn;
  logic [`PTR_W-1:0] rp_q, rp_d, rg_q, wg_b1_q, wg_b2_q, wp_b, count_b;
  logic [`PTR_W-1:0] x_b1_q, x_b2_q;
  logic [`DATA_W-1:0] out_q, aux_q, mail_one_b_q, mail_two_q;
  logic [1:0] pieces_left_q;
  bus_size_type cur_size_q;
  logic m1_req_b1_q, m1_req_b2_q, m1_seen_q, mail_one_flag_n_q;
  logic m2_req_q, m2_ack_b1_q, m2_ack_b2_q;
  logic m1_ack_q, m2_ack_q, m1_seen_ack, m2_seen_ack;

  ////////////////////////////////////////////////////////////////////////////
  // port a decode
  wire a_active = !port_a_ctrl.port_a_chip_select_n && port_a_ctrl.port_a_enable;
  wire a_write = a_active && port_a_ctrl.port_a_write_not_read;
  wire a_read = a_active && !port_a_ctrl.port_a_write_not_read;
  wire a_mail = port_a_ctrl.port_a_mailbox_select;
  wire full_n = (count_a != `FIFO_DEPTH);
  wire m1_busy = (m1_req_q != m1_ack_a2_q);
  wire fifo_write = a_write && !a_mail && full_n;
  wire mail_one_write = a_write && a_mail && !m1_busy;
  wire mail_two_read = a_read && a_mail;

  // fill seen from port a: local write pointer against synced read pointer
  assign rp_a = from_gray(rg_a2_q);
  assign count_a = wp_q - rp_a;
  assign wp_d = wp_q + {6'h00, fifo_write};

  // port a drives its lines only for a selected read
  assign port_a_data_oe = !port_a_ctrl.port_a_chip_select_n && !port_a_ctrl.port_a_write_not_read;
  assign port_a_data_out = mail_two_a_q;

  // full flags come straight from the synced compare, no extra stage
  assign port_a_status.full_flag_n = full_n;
  assign port_a_status.almost_full_flag_n = (count_a < (`FIFO_DEPTH - x_q));
  assign port_a_status.mail_two_flag_n = mail_two_flag_n_q;

  // offset strap is caught while reset is held, then stays put
  always_ff @(posedge clock) begin
    if (!rstn) begin
      unique case (offset_select)
        2'h0: x_q <= `OFFSET_PRESET_0;
        2'h1: x_q <= `OFFSET_PRESET_1;
        2'h2: x_q <= `OFFSET_PRESET_2;
        default: x_q <= `OFFSET_PRESET_3;
      endcase
    end
  end

  // write pointer and its gray copy move together
  always_ff @(posedge clock) begin
    if (!rstn) begin
      wp_q <= `PTR_RESET;
      wg_q <= `PTR_RESET;
    end else begin
      wp_q <= wp_d;
      wg_q <= to_gray(wp_d);
    end
  end

  // storage write has no reset; contents are don't-care until written
  always_ff @(posedge clock) begin
    if (fifo_write) begin
      mem[wp_q[`ADDR_W-1:0]] <= port_a_data_in;
    end
  end

  // read pointer into port a: two stages, a late edge slips one cycle
  always_ff @(posedge clock) begin
    if (!rstn) begin
      rg_a1_q <= `PTR_RESET;
      rg_a2_q <= `PTR_RESET;
    end else begin
      rg_a1_q <= rg_q;
      rg_a2_q <= rg_a1_q;
    end
  end

  // mail one: request toggle, busy until the port b side acknowledges
  always_ff @(posedge clock) begin
    if (!rstn) begin
      mail_one_q <= `DATA_RESET;
      m1_req_q <= 1'b0;
      m1_ack_a1_q <= 1'b0;
      m1_ack_a2_q <= 1'b0;
    end else begin
      m1_ack_a1_q <= m1_seen_ack;
      m1_ack_a2_q <= m1_ack_a1_q;
      if (mail_one_write) begin
        mail_one_q <= port_a_data_in;
        m1_req_q <= !m1_req_q;
      end
    end
  end

  // mail two arrives from port b; copy is safe as port b holds it while busy
  always_ff @(posedge clock) begin
    if (!rstn) begin
      mail_two_a_q <= `DATA_RESET;
      m2_req_a1_q <= 1'b0;
      m2_req_a2_q <= 1'b0;
      m2_seen_q <= 1'b0;
      mail_two_flag_n_q <= 1'b1;
    end else begin
      m2_req_a1_q <= m2_req_q;
      m2_req_a2_q <= m2_req_a1_q;
      if (m2_req_a2_q != m2_seen_q) begin
        mail_two_a_q <= mail_two_q;
        m2_seen_q <= m2_req_a2_q;
        mail_two_flag_n_q <= 1'b0;
      end else if (mail_two_read) begin
        mail_two_flag_n_q <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // port b reset: released two port b edges after rstn rises
  always_ff @(posedge port_b_clock) begin
    b_rst_pipe_q <= {b_rst_pipe_q[0], rstn};
  end
  assign b_rstn = b_rst_pipe_q[1];

  // ack lines handed across, mail one ack to port a and mail two ack to port b; held stable between toggles
  assign m1_seen_ack = m1_ack_q;
  assign m2_seen_ack = m2_ack_q;

  // port b decode
  wire b_active = !port_b_ctrl.port_b_chip_select_n && port_b_ctrl.port_b_enable;
  wire b_mail = port_b_ctrl.port_b_size_select_1 && port_b_ctrl.port_b_size_select_0;
  wire b_read = b_active && !port_b_ctrl.port_b_write_not_read;
  wire b_write = b_active && port_b_ctrl.port_b_write_not_read;
  wire m2_busy = (m2_req_q != m2_ack_b2_q);
  wire mail_one_read = b_read && b_mail;
  wire mail_two_write = b_write && b_mail && !m2_busy;
  wire fifo_read_req = b_read && !b_mail;

  // width decode: only long word when both sizes are low
  bus_size_type size_sel;
  assign size_sel = port_b_ctrl.port_b_size_select_0 ? size_word :
                    (port_b_ctrl.port_b_size_select_1 ? size_byte : size_long);
  wire [1:0] size_pieces = (size_sel == size_long) ? `PIECES_LONG :
                           ((size_sel == size_word) ? `PIECES_WORD : `PIECES_BYTE);

  // fill seen from port b
  assign wp_b = from_gray(wg_b2_q);
  assign count_b = wp_b - rp_q;
  wire word_avail = (count_b != `PTR_RESET);
  wire need_pop = (pieces_left_q == 2'h0) || (size_sel != cur_size_q);
  wire empty_n = word_avail || (pieces_left_q != 2'h0);
  wire fifo_read = fifo_read_req && (need_pop ? word_avail : 1'b1);
  wire pop = fifo_read && need_pop;
  assign rp_d = rp_q + {6'h00, pop};

  // piece selection: low lanes carry the piece, upper lanes read zero
  wire [`DATA_W-1:0] src = pop ? mem[rp_q[`ADDR_W-1:0]] : aux_q;
  wire [`DATA_W-1:0] piece = (size_sel == size_long) ? src :
                             ((size_sel == size_word) ? {18'h00000, src[`WORD_BITS-1:0]} :
                                                        {27'h0000000, src[`BYTE_BITS-1:0]});
  wire [`DATA_W-1:0] rest = (size_sel == size_word) ? (src >> `WORD_BITS) : (src >> `BYTE_BITS);

  // port b drives its lines for a selected read; mail one when both sizes high
  assign port_b_data_oe = !port_b_ctrl.port_b_chip_select_n && !port_b_ctrl.port_b_write_not_read;
  assign port_b_data_out = b_mail ? mail_one_b_q : out_q;
  assign port_b_status.empty_flag_n = empty_n;
  assign port_b_status.almost_empty_flag_n = (count_b > x_b2_q);
  assign port_b_status.mail_one_flag_n = mail_one_flag_n_q;

  // write pointer into port b: two stages, a late edge slips one cycle
  always_ff @(posedge port_b_clock) begin
    if (!b_rstn) begin
      wg_b1_q <= `PTR_RESET;
      wg_b2_q <= `PTR_RESET;
    end else begin
      wg_b1_q <= wg_q;
      wg_b2_q <= wg_b1_q;
    end
  end

  // offset is static after reset, a plain two-stage copy is enough
  always_ff @(posedge port_b_clock) begin
    x_b1_q <= x_q;
    x_b2_q <= x_b1_q;
  end

  // read pointer and output register; a width change drops unread pieces
  always_ff @(posedge port_b_clock) begin
    if (!b_rstn) begin
      rp_q <= `PTR_RESET;
      rg_q <= `PTR_RESET;
      out_q <= `DATA_RESET;
      aux_q <= `DATA_RESET;
      pieces_left_q <= 2'h0;
      cur_size_q <= size_long;
    end else begin
      rp_q <= rp_d;
      rg_q <= to_gray(rp_d);
      if (fifo_read) begin
        out_q <= piece;
        aux_q <= rest;
        pieces_left_q <= pop ? size_pieces : pieces_left_q - 2'h1;
        cur_size_q <= size_sel;
      end
    end
  end

  // mail one arrives from port a; read sets its flag high and acknowledges
  always_ff @(posedge port_b_clock) begin
    if (!b_rstn) begin
      mail_one_b_q <= `DATA_RESET;
      m1_req_b1_q <= 1'b0;
      m1_req_b2_q <= 1'b0;
      m1_seen_q <= 1'b0;
      m1_ack_q <= 1'b0;
      mail_one_flag_n_q <= 1'b1;
    end else begin
      m1_req_b1_q <= m1_req_q;
      m1_req_b2_q <= m1_req_b1_q;
      if (m1_req_b2_q != m1_seen_q) begin
        mail_one_b_q <= mail_one_q;
        m1_seen_q <= m1_req_b2_q;
        mail_one_flag_n_q <= 1'b0;
      end else if (mail_one_read) begin
        mail_one_flag_n_q <= 1'b1;
        m1_ack_q <= m1_seen_q;
      end
    end
  end

  // mail two written here, busy until port a acknowledges by reading
  always_ff @(posedge port_b_clock) begin
    if (!b_rstn) begin
      mail_two_q <= `DATA_RESET;
      m2_req_q <= 1'b0;
      m2_ack_b1_q <= 1'b0;
      m2_ack_b2_q <= 1'b0;
    end else begin
      m2_ack_b1_q <= m2_seen_ack;
      m2_ack_b2_q <= m2_ack_b1_q;
      if (mail_two_write) begin
        mail_two_q <= port_b_data_in;
        m2_req_q <= !m2_req_q;
      end
    end
  end

  // port a acknowledges mail two when it reads the mail while its flag is still low
  always_ff @(posedge clock) begin
    if (!rstn) begin
      m2_ack_q <= 1'b0;
    end else if (mail_two_read && mail_two_flag_n_q == 1'b0 && m2_req_a2_q == m2_seen_q) begin
      m2_ack_q <= m2_seen_q;
    end
  end

endmodule : dual_clock_fifo_port_flags
`default_nettype wire

// ===== logic/fifo_port_flags_map.svh
// offsets, widths, presets and reset values of the dual-clock fifo port block
`ifndef FIFO_PORT_FLAGS_MAP_SVH
`define FIFO_PORT_FLAGS_MAP_SVH

// storage shape
`define DATA_W 36
`define PTR_W 7
`define ADDR_W 6
`define FIFO_DEPTH 7'h40

// bus sizing piece widths on port b
`define WORD_BITS 18
`define BYTE_BITS 9
`define PIECES_LONG 2'h0
`define PIECES_WORD 2'h1
`define PIECES_BYTE 2'h3

// almost-flag offset presets, picked by the strap during reset
`define OFFSET_PRESET_0 7'h10
`define OFFSET_PRESET_1 7'h0C
`define OFFSET_PRESET_2 7'h08
`define OFFSET_PRESET_3 7'h04

// reset values
`define PTR_RESET 7'h00
`define DATA_RESET 36'h000000000

`endif

// ===== logic/fifo_port_flags_pkg.sv
// types shared by the dual-clock fifo port block and its bench
`default_nettype none
package fifo_port_flags_pkg;

  // port a control pins, synchronous to the port a clock
  typedef struct packed {
    logic port_a_chip_select_n;
    logic port_a_write_not_read;
    logic port_a_enable;
    logic port_a_mailbox_select;
  } port_a_ctrl_type;

  // port b control pins, synchronous to the port b clock
  typedef struct packed {
    logic port_b_chip_select_n;
    logic port_b_write_not_read;
    logic port_b_enable;
    logic port_b_size_select_1;
    logic port_b_size_select_0;
  } port_b_ctrl_type;

  // flags timed by the port a clock
  typedef struct packed {
    logic full_flag_n;
    logic almost_full_flag_n;
    logic mail_two_flag_n;
  } port_a_status_type;

  // flags timed by the port b clock
  typedef struct packed {
    logic empty_flag_n;
    logic almost_empty_flag_n;
    logic mail_one_flag_n;
  } port_b_status_type;

  // port b fifo read width
  typedef enum logic [1:0] {
    size_long,
    size_word,
    size_byte
  } bus_size_type;

endpackage : fifo_port_flags_pkg
`default_nettype wire

// ===== tb/fifo_port_checker.sv
// concurrent checks on the ports of the dual-clock fifo block
`timescale 1ns/1ns
`default_nettype none
`include "fifo_port_flags_map.svh"
module fifo_port_checker
  import fifo_port_flags_pkg::*;
(
  input wire logic clock,
  input wire logic rstn,
  input wire logic port_b_clock,
  input wire fifo_port_flags_pkg::port_a_ctrl_type port_a_ctrl,
  input wire logic port_a_data_oe,
  input wire fifo_port_flags_pkg::port_a_status_type port_a_status,
  input wire fifo_port_flags_pkg::port_b_ctrl_type port_b_ctrl,
  input wire logic [`DATA_W-1:0] port_b_data_out,
  input wire logic port_b_data_oe,
  input wire fifo_port_flags_pkg::port_b_status_type port_b_status
);
  // short names for decoded requests and flags
  wire logic a_cs = !port_a_ctrl.port_a_chip_select_n;
  wire logic a_go = a_cs && port_a_ctrl.port_a_enable;
  wire logic a_mb = a_go && port_a_ctrl.port_a_mailbox_select;
  wire logic a_w = port_a_ctrl.port_a_write_not_read;
  wire logic b_cs = !port_b_ctrl.port_b_chip_select_n;
  wire logic b_go = b_cs && port_b_ctrl.port_b_enable;
  wire logic b_mb = port_b_ctrl.port_b_size_select_1 && port_b_ctrl.port_b_size_select_0;
  wire logic b_w = port_b_ctrl.port_b_write_not_read;
  wire logic ff = port_a_status.full_flag_n;
  wire logic mt = port_a_status.mail_two_flag_n;
  wire logic ef = port_b_status.empty_flag_n;
  wire logic mo = port_b_status.mail_one_flag_n;

  a_drive_a: assert property (@(posedge clock) disable iff (!rstn)
    port_a_data_oe == (a_cs && !a_w)) else $error("port a drive wrong");
  b_drive_a: assert property (@(posedge port_b_clock) disable iff (!rstn)
    port_b_data_oe == (b_cs && !b_w)) else $error("port b drive wrong");
  two_clear_a: assert property (@(posedge clock) disable iff (!rstn)
    a_mb && !a_w |=> mt) else $error("mail two flag not set");
  one_clear_a: assert property (@(posedge port_b_clock) disable iff (!rstn)
    b_go && b_mb && !b_w |=> mo) else $error("mail one flag not set");
  one_set_a: assert property (@(posedge clock) disable iff (!rstn)
    a_mb && a_w && mo |-> ##[2:6] !mo) else $error("mail one flag not cleared");
  two_set_a: assert property (@(posedge port_b_clock) disable iff (!rstn)
    b_go && b_mb && b_w && mt |-> ##[1:5] !mt) else $error("mail two flag not cleared");
  empty_read_a: assert property (@(posedge port_b_clock) disable iff (!rstn)
    b_go && !b_w && !b_mb && !ef ##1 !b_mb |-> $stable(port_b_data_out)) else $error("read while empty");
  write_shows_a: assert property (@(posedge clock) disable iff (!rstn)
    a_go && !a_mb && a_w && ff && !ef |-> ##[1:5] ef) else $error("empty flag late");
  read_frees_a: assert property (@(posedge port_b_clock) disable iff (!rstn)
    b_go && !b_w && !b_mb && ef && !ff |-> ##[1:4] ff) else $error("full flag late");
  reset_flags_a: assert property (@(posedge clock) disable iff (!rstn)
    $rose(rstn) |-> ff && port_a_status.almost_full_flag_n) else $error("reset flags wrong");
endmodule : fifo_port_checker

bind dual_clock_fifo_port_flags fifo_port_checker i_checker (.clock(clock), .rstn(rstn),
  .port_b_clock(port_b_clock), .port_a_ctrl(port_a_ctrl), .port_a_data_oe(port_a_data_oe),
  .port_a_status(port_a_status), .port_b_ctrl(port_b_ctrl), .port_b_data_out(port_b_data_out),
  .port_b_data_oe(port_b_data_oe), .port_b_status(port_b_status));
`default_nettype wire

// ===== tb/port_b_host.sv
// host on port b: turns bench requests into port b clocked cycles
`timescale 1ns/1ns
`default_nettype none
`include "fifo_port_flags_map.svh"
module port_b_host
  import fifo_port_flags_pkg::*;
(
  input wire logic port_b_clock,
  input wire fifo_port_flags_pkg::port_b_ctrl_type want,
  input wire logic [`DATA_W-1:0] want_data,
  output var fifo_port_flags_pkg::port_b_ctrl_type port_b_ctrl,
  output var logic [`DATA_W-1:0] port_b_data_in
);
  // start deselected
  initial begin
    port_b_ctrl = 5'h10;
    port_b_data_in = 36'h000000000;
  end

  // data only driven on writes; otherwise lines wander so stale values never pass
  always @(posedge port_b_clock) begin
    port_b_ctrl <= #2 want;
    if (!want.port_b_chip_select_n && want.port_b_write_not_read) port_b_data_in <= #2 want_data;
    else port_b_data_in <= #2 ~port_b_data_in;
  end
endmodule : port_b_host
`default_nettype wire

// ===== tb/testbench.sv
// self-checking bench of the dual-clock fifo port block
`timescale 1ns/1ns
`default_nettype none
`include "fifo_port_flags_map.svh"
module testbench;
  import fifo_port_flags_pkg::*;
  logic clock, port_b_clock, rstn, port_a_data_oe, port_b_data_oe;
  logic [35:0] port_a_data_in, port_a_data_out, port_b_data_in, port_b_data_out, want_data;
  port_a_ctrl_type port_a_ctrl;
  port_b_ctrl_type want, port_b_ctrl;
  port_a_status_type port_a_status;
  port_b_status_type port_b_status;
  int fails, comparisons, cycles;
  logic [1:0] strap;
  int lx = `OFFSET_PRESET_3;

  // port b clock runs unrelated in phase
  initial begin
    clock = 0;
    forever #50 clock = ~clock;
  end
  initial begin
    port_b_clock = 0;
    #37;
    forever begin
      #62 port_b_clock = 1;
      #63 port_b_clock = 0;
    end
  end

  dual_clock_fifo_port_flags i_dut (.clock(clock), .rstn(rstn), .port_b_clock(port_b_clock),
    .offset_select(strap), .port_a_ctrl(port_a_ctrl), .port_a_data_in(port_a_data_in),
    .port_a_data_out(port_a_data_out), .port_a_data_oe(port_a_data_oe), .port_a_status(port_a_status),
    .port_b_ctrl(port_b_ctrl), .port_b_data_in(port_b_data_in), .port_b_data_out(port_b_data_out),
    .port_b_data_oe(port_b_data_oe), .port_b_status(port_b_status));
  port_b_host i_host (.port_b_clock(port_b_clock), .want(want), .want_data(want_data),
    .port_b_ctrl(port_b_ctrl), .port_b_data_in(port_b_data_in));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [35:0] got, input logic [35:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // n port a cycles; afterwards deselect and let the data lines wander
  task automatic a_do(input port_a_ctrl_type c, input logic [35:0] d, input int n);
    @(posedge clock);
    #2 port_a_ctrl = c;
    port_a_data_in = d;
    repeat (n) @(posedge clock);
    #2 port_a_ctrl = c | 4'h8;
    port_a_data_in = ~d;
  endtask : a_do

  // host copies the request one edge late, so n edges give n accesses
  task automatic b_do(input port_b_ctrl_type c, input logic [35:0] d, input int n);
    @(posedge port_b_clock);
    #2 want = c;
    want_data = d;
    repeat (n) @(posedge port_b_clock);
    #2 want = c | 5'h10;
  endtask : b_do

  // all four fifo flags against a fill level of n long words
  task automatic flags(input int n);
    chk(36'({port_a_status.full_flag_n, port_a_status.almost_full_flag_n}), 36'({n < 64, n < 64 - lx}));
    chk(36'({port_b_status.empty_flag_n, port_b_status.almost_empty_flag_n}), 36'({n > 0, n > lx}));
  endtask : flags

  task automatic fill_drain_test;
    for (int k = 1; k <= 65; k++) begin
      a_do(4'h6, 36'(k), 1);
      repeat (6) @(posedge clock);
      flags(k > 64 ? 64 : k);
    end
    for (int k = 1; k <= 65; k++) begin
      b_do(5'h04, 36'h000000000, 1);
      repeat (6) @(posedge clock);
      chk(port_b_data_out, 36'(k > 64 ? 64 : k));
      flags(k > 64 ? 0 : 64 - k);
    end
    $display("fill and drain test done");
  endtask : fill_drain_test

  // word then byte width; low piece first, empty only after the last piece
  task automatic sizes_test;
    logic [35:0] w;
    w = 36'h9ABCD1234;
    for (int s = 0; s < 2; s++) begin
      a_do(4'h6, w, 1);
      repeat (6) @(posedge clock);
      for (int p = 0; p < 2 + 2 * s; p++) begin
        chk(36'(port_b_status.empty_flag_n), 36'h000000001);
        b_do(s ? 5'h06 : 5'h05, 36'h000000000, 1);
        repeat (3) @(posedge clock);
        chk(s ? 36'(port_b_data_out[8:0]) : 36'(port_b_data_out[17:0]), s ? 36'(w[9*p+:9]) : 36'(w[18*p+:18]));
      end
      chk(36'(port_b_status.empty_flag_n), 36'h000000000);
    end
    $display("sizes test done");
  endtask : sizes_test

  task automatic mail_test;
    a_do(4'h7, 36'h50A0AF0F0, 1);
    repeat (6) @(posedge clock);
    chk(36'(port_b_status.mail_one_flag_n), 36'h000000000);
    b_do(5'h07, 36'h000000000, 1);
    repeat (3) @(posedge clock);
    chk(port_b_data_out, 36'h50A0AF0F0);
    chk(36'(port_b_status.mail_one_flag_n), 36'h000000001);
    b_do(5'h0F, 36'hC33335555, 1);
    repeat (6) @(posedge clock);
    chk(36'(port_a_status.mail_two_flag_n), 36'h000000000);
    a_do(4'h3, 36'h000000000, 1);
    chk(port_a_data_out, 36'hC33335555);
    chk(36'(port_a_status.mail_two_flag_n), 36'h000000001);
    $display("mail test done");
  endtask : mail_test

  // second reset in mid-run picks another preset; fill across the new threshold
  task automatic strap_test;
    strap = 2'h1;
    lx = `OFFSET_PRESET_1;
    @(posedge clock);
    #2 rstn = 0;
    repeat (20) @(posedge clock);
    #2 rstn = 1;
    repeat (4) @(posedge clock);
    flags(0);
    for (int k = 1; k <= lx + 1; k++) begin
      a_do(4'h6, 36'(k), 1);
      repeat (6) @(posedge clock);
      flags(k);
    end
    $display("strap test done");
  endtask : strap_test

  task automatic stop_test;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : stop_test

  // a hang ends the run well past the expected length
  always @(posedge clock) begin
    cycles++;
    if (cycles == 6000) begin
      fails++;
      stop_test;
    end
  end

  initial begin
    rstn = 0;
    strap = 2'h3;
    port_a_ctrl = 4'h8;
    port_a_data_in = 36'h000000000;
    want = 5'h10;
    want_data = 36'h000000000;
    repeat (20) @(posedge clock);
    #2 rstn = 1;
    repeat (4) @(posedge clock);
    flags(0);
    $display("reset test done");
    fill_drain_test;
    sizes_test;
    mail_test;
    strap_test;
    stop_test;
  end
endmodule : testbench
`default_nettype wire
